// file: logic/csr_guid_retry_control.sv
// APB register block: ID-ROM byte reader, async retry limits and the
// compare-swap engine over four bus management resources.
// Assumes ROM, transmit units and bus receive logic run on pclk.
`timescale 1ns/100ps
module csr_guid_retry_control
	import csr_pkg::*;
#(
	parameter bit ID_ROM_PRESENT = 1'b1,
	parameter bit DUAL_PHASE = 1'b1,
	parameter int ROM_AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [ROM_AW-1:0] rom_addr,
	output logic rom_req,
	input wire logic rom_ack,
	input wire logic [7:0] rom_data,
	input wire logic [N_UNIT-1:0] tx_want,
	input wire logic [N_UNIT-1:0] tx_done,
	input wire ack_kind_t tx_ack [N_UNIT],
	input wire logic fair_gap,
	input wire logic cycle_tick,
	output logic [N_UNIT-1:0] tx_grant,
	output logic [N_UNIT-1:0] tx_retry,
	output logic [N_UNIT-1:0] tx_drop,
	input wire logic bus_reset,
	input wire bus_req_t bus_req,
	output bus_resp_t bus_resp,
	input wire logic lock_ack_valid,
	input wire logic lock_ack_complete,
	output logic lock_response_error
);
	// Register and engine state
	logic rom_clr_q, rom_clr_d; // Address clear request
	logic rom_go_q, rom_go_d; // Read go bit
	logic [7:0] rom_byte_q, rom_byte_d; // Last byte read
	logic [ROM_AW-1:0] rom_addr_q, rom_addr_d;
	rom_st_t rom_st_q, rom_st_d;
	logic [2:0] sec_lim_q, sec_lim_d;
	logic [12:0] cyc_lim_q, cyc_lim_d;
	logic [3:0] max_q [N_UNIT];
	logic [3:0] max_d [N_UNIT];
	logic [31:0] swap_data_q, swap_data_d;
	logic [31:0] swap_cmp_q, swap_cmp_d;
	logic [1:0] sel_q, sel_d;
	logic done_q, done_d;
	logic host_pend_q, host_pend_d; // Host swap waiting for its slot
	logic [31:0] res_q [4];
	logic [31:0] res_d [4];
	bus_resp_t resp_q, resp_d;
	logic lerr_q, lerr_d;
	logic wr, rd; // APB access phase strobes
	logic [31:0] rdata;
	logic hit;

	// Compare-swap result: new value only if the old one matches
	function automatic logic [31:0] cas(input logic [31:0] old, input logic [31:0] cmp,
		input logic [31:0] nv);
		cas = (old == cmp) ? nv : old;
	endfunction : cas

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1; // Zero-wait slave
	assign pslverr = psel & penable & ~hit;
	assign prdata = rdata;
	assign rom_addr = rom_addr_q;
	assign rom_req = (rom_st_q == ROM_REQ);
	assign bus_resp = resp_q;
	assign lock_response_error = lerr_q;

	// Read mux and address decode
	always_comb begin
		hit = 1'b1;
		rdata = 32'h00000000;
		unique case (paddr)
			OFS_ID_ROM: begin
				if (ID_ROM_PRESENT) begin
					rdata[B_ROM_CLR] = rom_clr_q;
					rdata[B_ROM_GO] = rom_go_q;
					rdata[B_ROM_BYTE +: 8] = rom_byte_q;
				end
			end
			OFS_RETRY: begin
				rdata[B_SEC +: 3] = sec_lim_q;
				rdata[B_CYC +: 13] = cyc_lim_q;
				rdata[B_PHYS_CNT +: 4] = max_q[U_PHYS];
				rdata[B_SWR_CNT +: 4] = max_q[U_SWR];
				rdata[B_REQ_CNT +: 4] = max_q[U_REQ];
			end
			OFS_SWAP_DATA: rdata = swap_data_q;
			OFS_SWAP_CMP: rdata = swap_cmp_q;
			OFS_SWAP_CTRL: begin
				rdata[B_DONE] = done_q;
				rdata[B_SEL +: 2] = sel_q;
			end
			default: hit = 1'b0;
		endcase
	end

	// Next state of registers, ROM reader and resources
	always_comb begin
		logic [31:0] old;
		logic bus_op;
		old = 32'h00000000;
		bus_op = 1'b0;
		rom_clr_d = rom_clr_q;
		rom_go_d = rom_go_q;
		rom_byte_d = rom_byte_q;
		rom_addr_d = rom_addr_q;
		rom_st_d = rom_st_q;
		sec_lim_d = sec_lim_q;
		cyc_lim_d = cyc_lim_q;
		max_d = max_q;
		swap_data_d = swap_data_q;
		swap_cmp_d = swap_cmp_q;
		sel_d = sel_q;
		done_d = done_q;
		host_pend_d = host_pend_q;
		res_d = res_q;
		resp_d = '0;
		lerr_d = lock_ack_valid & ~lock_ack_complete;
		// ROM register writes; go only latches a 0-to-1 change
		if (wr && paddr == OFS_ID_ROM && ID_ROM_PRESENT) begin
			if (pwdata[B_ROM_CLR])
				rom_clr_d = 1'b1;
			if (pwdata[B_ROM_GO] && !rom_go_q)
				rom_go_d = 1'b1;
		end
		// Clear the address; read byte is left untouched
		if (rom_clr_q && rom_st_q == ROM_IDLE) begin
			rom_addr_d = '0;
			rom_clr_d = 1'b0;
		end
		unique case (rom_st_q)
			ROM_IDLE: if (rom_go_q && !rom_clr_q) rom_st_d = ROM_REQ;
			ROM_REQ: rom_st_d = ROM_WAIT;
			ROM_WAIT: begin
				if (rom_ack) begin
					rom_byte_d = rom_data;
					rom_addr_d = rom_addr_q + 1'b1;
					rom_go_d = 1'b0;
					rom_st_d = ROM_IDLE;
				end
			end
			default: rom_st_d = ROM_IDLE;
		endcase
		// Retry limits; time fields frozen at zero without dual-phase
		if (wr && paddr == OFS_RETRY) begin
			if (DUAL_PHASE) begin
				sec_lim_d = pwdata[B_SEC +: 3];
				cyc_lim_d = pwdata[B_CYC +: 13];
			end
			max_d[U_PHYS] = pwdata[B_PHYS_CNT +: 4];
			max_d[U_SWR] = pwdata[B_SWR_CNT +: 4];
			max_d[U_REQ] = pwdata[B_REQ_CNT +: 4];
		end
		if (wr && paddr == OFS_SWAP_DATA)
			swap_data_d = pwdata;
		if (wr && paddr == OFS_SWAP_CMP)
			swap_cmp_d = pwdata;
		// Bus side: only quadlet read and lock; one op per cycle
		bus_op = bus_req.valid && (bus_req.kind == TT_QREAD || bus_req.kind == TT_QLOCK);
		if (bus_req.valid) begin
			resp_d.valid = 1'b1;
			resp_d.type_err = ~bus_op;
			resp_d.data = res_q[bus_req.sel];
			if (bus_req.kind == TT_QLOCK)
				res_d[bus_req.sel] = cas(res_q[bus_req.sel], bus_req.arg, bus_req.data);
		end
		// Host swap runs only in a cycle with no bus op
		if (host_pend_q && !bus_op) begin
			old = res_q[sel_q];
			res_d[sel_q] = cas(old, swap_cmp_q, swap_data_q);
			swap_data_d = old;
			done_d = 1'b1;
			host_pend_d = 1'b0;
		end
		// Control write launches the swap and clears done
		if (wr && paddr == OFS_SWAP_CTRL) begin
			sel_d = pwdata[B_SEL +: 2];
			done_d = 1'b0;
			host_pend_d = 1'b1;
		end
		// Bus reset reloads the resources
		if (bus_reset) begin
			res_d[0] = RST_BM_ID;
			res_d[1] = RST_BW;
			res_d[2] = RST_CH;
			res_d[3] = RST_CH;
		end
	end

	// Register stage for the register file and engines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_clr_q <= 1'b0;
			rom_go_q <= 1'b0;
			rom_byte_q <= 8'h00;
			rom_addr_q <= '0;
			rom_st_q <= ROM_IDLE;
			sec_lim_q <= 3'h0;
			cyc_lim_q <= 13'h0000;
			for (int i = 0; i < N_UNIT; i++)
				max_q[i] <= 4'h0;
			swap_data_q <= 32'h00000000;
			swap_cmp_q <= 32'h00000000;
			sel_q <= 2'h0;
			done_q <= 1'b1;
			host_pend_q <= 1'b0;
			res_q[0] <= RST_BM_ID;
			res_q[1] <= RST_BW;
			res_q[2] <= RST_CH;
			res_q[3] <= RST_CH;
			resp_q <= '0;
			lerr_q <= 1'b0;
		end else begin
			rom_clr_q <= rom_clr_d;
			rom_go_q <= rom_go_d;
			rom_byte_q <= rom_byte_d;
			rom_addr_q <= rom_addr_d;
			rom_st_q <= rom_st_d;
			sec_lim_q <= sec_lim_d;
			cyc_lim_q <= cyc_lim_d;
			max_q <= max_d;
			swap_data_q <= swap_data_d;
			swap_cmp_q <= swap_cmp_d;
			sel_q <= sel_d;
			done_q <= done_d;
			host_pend_q <= host_pend_d;
			res_q <= res_d;
			resp_q <= resp_d;
			lerr_q <= lerr_d;
		end
	end

	// Retry state per transmit unit
	logic [3:0] cnt_q [N_UNIT];
	logic [3:0] cnt_d [N_UNIT];
	logic [N_UNIT-1:0] fair_q, fair_d; // Waiting for a fairness gap
	logic [N_UNIT-1:0] retry_d, drop_d, retry_q, drop_q;
	logic [2:0] el_sec_q, el_sec_d; // Elapsed time of physical retries
	logic [12:0] el_cyc_q, el_cyc_d;
	logic expired;

	// Dual-phase window is off when both limits are zero
	assign expired = DUAL_PHASE && ({sec_lim_q, cyc_lim_q} != 16'h0000)
		&& ({el_sec_q, el_cyc_q} >= {sec_lim_q, cyc_lim_q});
	assign tx_retry = retry_q;
	assign tx_drop = drop_q;

	// Grant: fixed priority among units not parked on fairness
	always_comb begin
		logic taken;
		taken = 1'b0;
		tx_grant = '0;
		for (int u = 0; u < N_UNIT; u++) begin
			if (tx_want[u] && !fair_q[u] && !taken) begin
				tx_grant[u] = 1'b1;
				taken = 1'b1;
			end
		end
	end

	// Next retry counts and outcomes
	always_comb begin
		cnt_d = cnt_q;
		fair_d = fair_q;
		retry_d = '0;
		drop_d = '0;
		el_sec_d = el_sec_q;
		el_cyc_d = el_cyc_q;
		if (fair_gap)
			fair_d = '0;
		// Physical retry clock, modulo 8000 cycles per second
		if (cnt_q[U_PHYS] != 4'h0 && cycle_tick) begin
			if (el_cyc_q == CYC_PER_SEC - 13'h0001) begin
				el_cyc_d = 13'h0000;
				el_sec_d = el_sec_q + 3'h1;
			end else begin
				el_cyc_d = el_cyc_q + 13'h0001;
			end
		end
		for (int u = 0; u < N_UNIT; u++) begin
			if (tx_done[u]) begin
				if (tx_ack[u] == ACK_BUSY || tx_ack[u] == ACK_DATA_ERR) begin
					if (cnt_q[u] < max_q[u] && !(u == U_PHYS && expired)) begin
						cnt_d[u] = cnt_q[u] + 4'h1;
						retry_d[u] = 1'b1;
						fair_d[u] = 1'b1;
					end else begin
						cnt_d[u] = 4'h0;
						drop_d[u] = 1'b1;
					end
				end else begin
					cnt_d[u] = 4'h0;
					drop_d[u] = (tx_ack[u] != ACK_COMPLETE);
				end
			end
		end
		if (cnt_d[U_PHYS] == 4'h0) begin
			el_sec_d = 3'h0;
			el_cyc_d = 13'h0000;
		end
	end

	// Register stage for retry state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int u = 0; u < N_UNIT; u++)
				cnt_q[u] <= 4'h0;
			fair_q <= '0;
			retry_q <= '0;
			drop_q <= '0;
			el_sec_q <= 3'h0;
			el_cyc_q <= 13'h0000;
		end else begin
			cnt_q <= cnt_d;
			fair_q <= fair_d;
			retry_q <= retry_d;
			drop_q <= drop_d;
			el_sec_q <= el_sec_d;
			el_cyc_q <= el_cyc_d;
		end
	end

	// Checks
	a_rom_clr_done: assert property (@(posedge pclk) disable iff (!presetn)
		rom_clr_q && rom_st_q == ROM_IDLE |=> !rom_clr_q && rom_addr_q == '0)
		else $error("address clear did not complete");
	a_rom_byte_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(rom_st_q == ROM_WAIT && rom_ack) |=> $stable(rom_byte_q))
		else $error("read byte changed without a read");
	a_rom_go_start: assert property (@(posedge pclk) disable iff (!presetn)
		rom_st_q == ROM_IDLE && !rom_go_q |=> rom_st_q == ROM_IDLE)
		else $error("ROM read began without go");
	a_rom_read_end: assert property (@(posedge pclk) disable iff (!presetn)
		rom_st_q == ROM_WAIT && rom_ack |=> !rom_go_q
		&& rom_addr_q == $past(rom_addr_q) + 1'b1 && rom_byte_q == $past(rom_data))
		else $error("ROM read completion wrong");
	a_retry_cause: assert property (@(posedge pclk) disable iff (!presetn)
		retry_q[U_REQ] |-> $past(tx_ack[U_REQ]) inside {ACK_BUSY, ACK_DATA_ERR})
		else $error("retry after wrong acknowledge");
	a_retry_bound: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_q[U_PHYS] <= max_q[U_PHYS] || $changed(max_q[U_PHYS]) || $past(wr))
		else $error("physical retries beyond limit");
	a_limits_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		DUAL_PHASE || {sec_lim_q, cyc_lim_q} == 16'h0000)
		else $error("time limits changed without dual-phase");
	a_type_err: assert property (@(posedge pclk) disable iff (!presetn)
		bus_req.valid && bus_req.kind == TT_OTHER |=> resp_q.type_err)
		else $error("bad transaction not refused");
	a_lock_err: assert property (@(posedge pclk) disable iff (!presetn)
		lock_ack_valid && !lock_ack_complete |=> lock_response_error)
		else $error("lock response error missed");
	a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_SWAP_CTRL |=> !done_q ##[1:2] done_q || bus_req.valid)
		else $error("done flag sequence wrong");
	a_host_serial: assert property (@(posedge pclk) disable iff (!presetn)
		host_pend_q && bus_req.valid && bus_req.kind != TT_OTHER |=> host_pend_q)
		else $error("host swap interleaved with bus swap");
endmodule : csr_guid_retry_control

// file: logic/csr_pkg.sv
// Constants, field layouts and carrier types for the CSR/ID-ROM/retry block.
// Assumes a 32-bit APB host port and same-clock transmit and bus-receive logic.
package csr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_ID_ROM = 8'h00;
	localparam logic [7:0] OFS_RETRY = 8'h04;
	localparam logic [7:0] OFS_SWAP_DATA = 8'h08;
	localparam logic [7:0] OFS_SWAP_CMP = 8'h0C;
	localparam logic [7:0] OFS_SWAP_CTRL = 8'h10;
	// id_rom_access fields
	localparam int B_ROM_CLR = 31;
	localparam int B_ROM_GO = 25;
	localparam int B_ROM_BYTE = 16;
	// async_retry_limits fields
	localparam int B_SEC = 29;
	localparam int B_CYC = 16;
	localparam int B_PHYS_CNT = 8;
	localparam int B_SWR_CNT = 4;
	localparam int B_REQ_CNT = 0;
	// swap_control fields
	localparam int B_DONE = 31;
	localparam int B_SEL = 0;
	// Resource reset values
	localparam logic [31:0] RST_BM_ID = 32'h0000003F;
	localparam logic [31:0] RST_BW = 32'h00001333;
	localparam logic [31:0] RST_CH = 32'hFFFFFFFF;
	// Cycle timer: cycles per second, modulo 8000
	localparam logic [12:0] CYC_PER_SEC = 13'h1F40;
	// Transmit units, highest priority first
	localparam int U_PHYS = 0;
	localparam int U_SWR = 1;
	localparam int U_REQ = 2;
	localparam int N_UNIT = 3;
	// Acknowledge outcome of one transmit attempt
	typedef enum logic [2:0] {
		ACK_COMPLETE = 3'h0,
		ACK_BUSY = 3'h1,
		ACK_DATA_ERR = 3'h2,
		ACK_MISSING = 3'h3,
		ACK_OTHER = 3'h4
	} ack_kind_t;
	// Bus transaction kinds seen at the resources
	typedef enum logic [1:0] {
		TT_QREAD = 2'h0,
		TT_QLOCK = 2'h1,
		TT_OTHER = 2'h2
	} tcode_t;
	// Bus-side request to the resources
	typedef struct packed {
		logic valid;
		tcode_t kind;
		logic [1:0] sel;
		logic [31:0] arg;
		logic [31:0] data;
	} bus_req_t;
	// Bus-side answer
	typedef struct packed {
		logic valid;
		logic type_err;
		logic [31:0] data;
	} bus_resp_t;
	// ROM sequencer states
	typedef enum logic [1:0] {
		ROM_IDLE = 2'b00,
		ROM_REQ = 2'b01,
		ROM_WAIT = 2'b10
	} rom_st_t;
endpackage : csr_pkg

// file: tb/id_rom_model.sv
// ID-ROM stand-in that answers each byte request after a varying delay.
// Assumes rom_req is a one-cycle pulse on pclk and rom_addr holds meanwhile.
`timescale 1ns/100ps
module id_rom_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rom_req,
	input wire logic [7:0] rom_addr,
	output logic rom_ack,
	output logic [7:0] rom_data
);
	int wait_n; // Cycles left until the answer
	// Data is valid only beside ack; otherwise it keeps changing, so a
	// design that samples it late sees garbage, not a lucky old byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_ack <= 1'b0;
			rom_data <= 8'hFF;
			wait_n = 0;
		end else begin
			rom_ack <= 1'b0;
			rom_data <= ~rom_data;
			if (rom_req) begin // One to four cycles: prompt and slow
				wait_n = 1 + $urandom % 4;
			end else if (wait_n > 0) begin
				wait_n--;
				if (wait_n == 0) begin
					rom_ack <= 1'b1;
					rom_data <= rom_addr ^ 8'h5A;
				end
			end
		end
	end
endmodule : id_rom_model

// file: tb/csr_guid_retry_control_tb.sv
// Self-checking bench: APB host, retry units, bus-side resource traffic.
// Assumes zero-wait APB and registered one-cycle pulses from the block.
`timescale 1ns/100ps
module csr_guid_retry_control_tb
	import csr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v, w;
	logic pready, pslverr, er, rom_req, rom_ack;
	logic [7:0] rom_addr, rom_data;
	logic [2:0] tx_want = 3'h0, tx_done = 3'h0, tx_grant, tx_retry, tx_drop;
	ack_kind_t tx_ack [N_UNIT] = '{default: ACK_COMPLETE};
	logic fair_gap = 1'b0, cycle_tick = 1'b0, bus_reset = 1'b0;
	logic lock_ack_valid = 1'b0, lock_ack_complete = 1'b0, lock_response_error;
	bus_req_t bus_req = '0;
	bus_resp_t bus_resp;
	logic [31:0] res [4]; // Expected resource contents
	int fail_count = 0, n_checks = 0;
	always #4 pclk = ~pclk;
	csr_guid_retry_control i_csr_guid_retry_control (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
		.rom_req(rom_req), .rom_ack(rom_ack), .rom_data(rom_data), .tx_want(tx_want),
		.tx_done(tx_done), .tx_ack(tx_ack), .fair_gap(fair_gap), .cycle_tick(cycle_tick),
		.tx_grant(tx_grant), .tx_retry(tx_retry), .tx_drop(tx_drop), .bus_reset(bus_reset),
		.bus_req(bus_req), .bus_resp(bus_resp), .lock_ack_valid(lock_ack_valid),
		.lock_ack_complete(lock_ack_complete), .lock_response_error(lock_response_error));
	id_rom_model i_id_rom_model (.pclk(pclk), .presetn(presetn), .rom_req(rom_req),
		.rom_addr(rom_addr), .rom_ack(rom_ack), .rom_data(rom_data));
	// Byte the ROM stand-in holds at an address
	function automatic logic [7:0] rom_byte(input logic [7:0] a);
		return a ^ 8'h5A;
	endfunction : rom_byte
	// Bits the random test values use in each resource
	function automatic logic [31:0] msk(input int s);
		return s == 0 ? 32'h3F : (s == 1 ? 32'h1FFF : 32'hFFFFFFFF);
	endfunction : msk
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Read until a bit reaches a level, bounded
	task automatic poll(input logic [7:0] a, input int b, input logic lvl);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (rd[b] !== lvl && n < 50);
		chk(32'(rd[b]), 32'(lvl));
	endtask : poll
	// One transmit outcome; e is the expected {retry, drop}
	task automatic attempt(input int u, input ack_kind_t k, input logic [1:0] e);
		@(posedge pclk);
		tx_done[u] <= 1'b1;
		tx_ack[u] <= k;
		@(posedge pclk);
		tx_done[u] <= 1'b0;
		#1;
		chk(32'({tx_retry[u], tx_drop[u]}), 32'(e));
	endtask : attempt
	task automatic pulse(input int which);
		@(posedge pclk);
		if (which == 0) fair_gap <= 1'b1;
		else if (which == 1) bus_reset <= 1'b1;
		else cycle_tick <= 1'b1;
		@(posedge pclk);
		fair_gap <= 1'b0;
		bus_reset <= 1'b0;
		cycle_tick <= 1'b0;
		#1;
	endtask : pulse
	// One bus-side request; the answer is settled on return
	task automatic bus(input tcode_t k, input int s, input logic [31:0] c, d);
		@(posedge pclk);
		bus_req <= '{1'b1, k, 2'(s), c, d};
		@(posedge pclk);
		bus_req.valid <= 1'b0;
		#1;
	endtask : bus
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// Watchdog: far beyond the few hundred cycles the tests need
	initial begin
		#400000;
		chk(32'h0, 32'h1);
		stop_test();
	end
	initial begin
		void'($urandom(32'h04BBED1B));
		res = '{RST_BM_ID, RST_BW, RST_CH, RST_CH};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_SWAP_CTRL, 32'h0);
		chk(32'(rd[B_DONE]), 32'h1);
		apb(1'b0, OFS_ID_ROM, 32'h0);
		chk(rd & 32'h82000000, 32'h0);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		$display("test reset done");
		// Two bytes, then restart from byte zero
		for (int i = 0; i < 3; i++) begin
			if (i == 2) begin
				apb(1'b1, OFS_ID_ROM, 32'h1 << B_ROM_CLR);
				poll(OFS_ID_ROM, B_ROM_CLR, 1'b0);
				chk(32'(rd[B_ROM_BYTE +: 8]), 32'(rom_byte(8'h01)));
			end
			apb(1'b1, OFS_ID_ROM, 32'h1 << B_ROM_GO);
			poll(OFS_ID_ROM, B_ROM_GO, 1'b0);
			chk(32'(rd[B_ROM_BYTE +: 8]), 32'(rom_byte(8'(i % 2))));
			chk(32'(rom_addr), 32'(i % 2 + 1));
		end
		$display("test rom done");
		repeat (4) begin
			v = $urandom & 32'hFFFF0FFF;
			apb(1'b1, OFS_RETRY, v);
			apb(1'b0, OFS_RETRY, 32'h0);
			chk(rd, v);
		end
		// Limits zero keep dual-phase off; each count allows one retry
		apb(1'b1, OFS_RETRY, 32'h00000111);
		for (int u = 0; u < N_UNIT; u++) begin
			@(posedge pclk);
			tx_want <= 3'(1 << u);
			attempt(u, u == 1 ? ACK_DATA_ERR : ACK_BUSY, 2'b10);
			@(posedge pclk);
			tx_want <= 3'h7;
			#1;
			chk(32'(tx_grant), u == 0 ? 32'h2 : 32'h1);
			@(posedge pclk);
			tx_want <= 3'(1 << u);
			pulse(0);
			chk(32'(tx_grant), 32'(1 << u));
			attempt(u, ACK_BUSY, 2'b01);
			attempt(u, ACK_MISSING, 2'b01);
			attempt(u, ACK_OTHER, 2'b01);
			attempt(u, ACK_COMPLETE, 2'b00);
		end
		// Two bus cycles of retrying meet a two-cycle limit: dropped
		apb(1'b1, OFS_RETRY, 32'h00020F00);
		attempt(0, ACK_BUSY, 2'b10);
		pulse(2);
		pulse(2);
		attempt(0, ACK_BUSY, 2'b01);
		$display("test retry done");
		for (int s = 0; s < 4; s++) begin
			v = $urandom & msk(s);
			w = $urandom & msk(s);
			bus(TT_QREAD, s, 32'h0, 32'h0);
			chk(bus_resp.data, res[s]);
			bus(TT_OTHER, s, res[s], v);
			chk(32'({bus_resp.valid, bus_resp.type_err}), 32'h3);
			bus(TT_QLOCK, s, ~res[s], v);
			chk(bus_resp.data, res[s]);
			bus(TT_QLOCK, s, res[s], v);
			chk(bus_resp.data, res[s]);
			apb(1'b1, OFS_SWAP_DATA, w);
			apb(1'b1, OFS_SWAP_CMP, v);
			// A bus read lands on the cycle the host swap would take
			fork
				apb(1'b1, OFS_SWAP_CTRL, 32'(s));
				begin
					repeat (2) @(posedge pclk);
					bus(TT_QREAD, s, 32'h0, 32'h0);
				end
			join
			chk(bus_resp.data, v);
			poll(OFS_SWAP_CTRL, B_DONE, 1'b1);
			apb(1'b0, OFS_SWAP_DATA, 32'h0);
			chk(rd, v);
			bus(TT_QREAD, s, 32'h0, 32'h0);
			chk(bus_resp.data, w);
		end
		pulse(1);
		for (int s = 0; s < 4; s++) begin
			bus(TT_QREAD, s, 32'h0, 32'h0);
			chk(bus_resp.data, res[s]);
		end
		for (int c = 0; c < 2; c++) begin
			@(posedge pclk);
			lock_ack_valid <= 1'b1;
			lock_ack_complete <= c[0];
			@(posedge pclk);
			lock_ack_valid <= 1'b0;
			#1;
			chk(32'(lock_response_error), 32'(!c[0]));
		end
		$display("test swap done");
		stop_test();
	end
endmodule : csr_guid_retry_control_tb
